// ==== core/snbl_pkg.sv ====
package snbl_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned BAUD_HZ_DEFAULT = 1_000_000;
    localparam int unsigned DIV_W           = 16;

    // ------------------------------------------------------------
    // Line constants
    // ------------------------------------------------------------
    localparam int unsigned STUFF_RUN   = 5;
    localparam int unsigned ABORT_RUN   = 7;
    localparam int unsigned IDLE_RUN    = 15;
    localparam int unsigned RAW_RUN     = 8;
    localparam int unsigned IFS_MIN     = 8;
    localparam logic [7:0]  FLAG_BYTE   = 8'h7E;
    localparam logic [7:0]  RAW_ONES    = 8'hFF;
    localparam logic [7:0]  PREAMBLE_B  = 8'h55;
    localparam logic        LINE_REST   = 1'b1;
    localparam int unsigned RUN_W       = 5;
    localparam int unsigned BIT_CNT_W   = 4;

    // ------------------------------------------------------------
    // Byte kinds on the transmit side
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SNBL_KIND_DATA = 2'b00,
        SNBL_KIND_CRC  = 2'b01,
        SNBL_KIND_FLAG = 2'b10,
        SNBL_KIND_PRE  = 2'b11
    } snbl_kind_t;

    typedef struct packed {
        logic [7:0] data;
        snbl_kind_t kind;
    } snbl_tx_byte_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } snbl_rx_byte_t;

    typedef enum logic [1:0] {
        SNBL_TX_IDLE  = 2'b00,
        SNBL_TX_SHIFT = 2'b01,
        SNBL_TX_IFS   = 2'b10
    } snbl_tx_state_t;

endpackage

// ==== core/snbl_nrzi_rx.sv ====
`timescale 1ns/1ns
// NRZI decoder with run counting of decoded ones
module snbl_nrzi_rx
    import snbl_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             bit_tick,
    input  wire logic             nrzi_on,
    input  wire logic             line_in,
    output logic                  bit_valid,
    output logic                  bit_value,
    output logic [RUN_W-1:0]      ones_run
);
    typedef struct packed {
        logic             prev_level;
        logic             bit_valid;
        logic             bit_value;
        logic [RUN_W-1:0] ones_run;
    } snbl_rxd_state_t;

    snbl_rxd_state_t st;
    snbl_rxd_state_t next_st;

    // Decode one line sample per bit time; run counter saturates
    always_comb begin
        logic dec;
        dec = 1'b0;
        next_st = st;
        next_st.bit_valid = 1'b0;
        if (bit_tick) begin
            dec = nrzi_on ? (line_in == st.prev_level) : line_in;
            next_st.prev_level = line_in;
            next_st.bit_valid = 1'b1;
            next_st.bit_value = dec;
            if (!dec) begin
                next_st.ones_run = '0;
            end else if (st.ones_run != '1) begin
                next_st.ones_run = st.ones_run + RUN_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '{prev_level: LINE_REST, bit_valid: 1'b0, bit_value: 1'b0,
                    ones_run: '0};
        end else begin
            st <= next_st;
        end
    end

    assign bit_valid = st.bit_valid;
    assign bit_value = st.bit_value;
    assign ones_run  = st.ones_run;
endmodule

// ==== core/snbl_line.sv ====
`timescale 1ns/1ns
module snbl_line
    import snbl_pkg::*;
#(
    parameter int unsigned  BAUD_HZ = BAUD_HZ_DEFAULT,
    parameter logic [DIV_W-1:0] BIT_DIV = DIV_W'(CLK_HZ / BAUD_HZ)
)(
    input  wire logic            mclk,
    input  wire logic            reset,
    input  wire logic            sdlc_mode,
    input  wire logic            internal_baud,
    input  wire logic            raw_mode,
    input  wire logic            tx_enable_bit,
    input  wire logic            rx_enable_bit,
    input  wire logic [7:0]      interframe_space_count,
    input  wire snbl_tx_byte_t   tx_byte_queue,
    input  wire logic            tx_valid,
    input  wire logic            tx_last,
    output logic                 tx_ready,
    output logic                 tx_line,
    output logic                 line_driver_enable_out,
    input  wire logic            rx_line,
    input  wire logic            line_idle_clear,
    input  wire logic            rx_abort_clear,
    output snbl_rx_byte_t        rx_byte,
    output logic                 rx_byte_valid,
    output logic                 rx_frame_end,
    output logic                 rx_abort_flag,
    output logic                 line_idle_flag
);
    import snbl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DIV_W-1:0]     div_cnt;
        logic                 tick;
        snbl_tx_state_t       tx_st;
        logic [7:0]           tx_sh;
        snbl_kind_t           tx_kind;
        logic                 tx_raw;
        logic                 tx_is_last;
        logic [BIT_CNT_W-1:0] tx_bits;
        logic [2:0]           tx_ones;
        logic                 tx_stuff;
        logic                 tx_level;
        logic                 den_n;
        logic [7:0]           ifs_cnt;
        logic                 tx_ready;
        logic                 in_frame;
        logic                 got_data;
        logic [7:0]           flag_sh;
        logic [7:0]           rx_sh;
        logic [BIT_CNT_W-1:0] rx_bits;
        logic [7:0]           rx_hold;
        logic                 rx_hold_ok;
        snbl_rx_byte_t        rx_out;
        logic                 rx_out_valid;
        logic                 rx_end;
        logic                 abort_flag;
        logic                 idle_flag;
    } snbl_state_t;

    snbl_state_t st;
    snbl_state_t next_st;

    logic             rb_valid;
    logic             rb_value;
    logic [RUN_W-1:0] rb_run;
    logic             nrzi_on;

    // Bit reversal used for the MSB-first CRC bytes
    function automatic logic [7:0] snbl_rev8(input logic [7:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    // NRZI only with SDLC selected and the internal bit clock in use
    assign nrzi_on = sdlc_mode && internal_baud;

    snbl_nrzi_rx u_rx (
        .mclk      (mclk),
        .reset     (reset),
        .bit_tick  (st.tick),
        .nrzi_on   (nrzi_on),
        .line_in   (rx_line),
        .bit_valid (rb_valid),
        .bit_value (rb_value),
        .ones_run  (rb_run)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic out_bit;
        logic [7:0] flag_n;
        out_bit = 1'b1;
        flag_n  = '0;
        next_st = st;
        next_st.rx_out_valid = 1'b0;
        next_st.rx_end = 1'b0;

        // Bit-time divider; one tick per bit on both directions
        if (st.div_cnt == BIT_DIV - DIV_W'(1)) begin
            next_st.div_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + DIV_W'(1);
            next_st.tick = 1'b0;
        end

        // Transmit side
        next_st.tx_ready = 1'b0;
        if (!tx_enable_bit) begin
            // Disable drops the frame and holds the line high
            next_st.tx_st = SNBL_TX_IDLE;
            next_st.tx_level = LINE_REST;
            next_st.tx_ones = '0;
            next_st.tx_stuff = 1'b0;
            next_st.den_n = 1'b1;
            next_st.ifs_cnt = interframe_space_count;
            if (st.tx_st == SNBL_TX_SHIFT || st.tx_st == SNBL_TX_IFS) begin
                next_st.tx_st = SNBL_TX_IFS;
            end
        end else begin
            unique case (st.tx_st)
                SNBL_TX_IDLE: begin
                    next_st.den_n = 1'b1;
                    next_st.tx_ready = 1'b1;
                    if (tx_valid && st.tx_ready) begin
                        next_st.tx_ready = 1'b0;
                        next_st.tx_kind = tx_byte_queue.kind;
                        next_st.tx_raw = raw_mode;
                        next_st.tx_is_last = tx_last;
                        next_st.tx_bits = '0;
                        next_st.den_n = 1'b0;
                        next_st.tx_st = SNBL_TX_SHIFT;
                        // CRC MSB first, others LSB first; shift out bit 0
                        if (tx_byte_queue.kind == SNBL_KIND_CRC) begin
                            next_st.tx_sh = snbl_rev8(tx_byte_queue.data);
                        end else if (tx_byte_queue.kind == SNBL_KIND_PRE) begin
                            next_st.tx_sh = PREAMBLE_B;
                        end else begin
                            next_st.tx_sh = tx_byte_queue.data;
                        end
                    end
                end
                SNBL_TX_SHIFT: begin
                    if (st.tick) begin
                        if (st.tx_stuff) begin
                            out_bit = 1'b0;
                            next_st.tx_stuff = 1'b0;
                            next_st.tx_ones = '0;
                        end else begin
                            out_bit = st.tx_sh[0];
                            next_st.tx_sh = {1'b0, st.tx_sh[7:1]};
                            next_st.tx_bits = st.tx_bits + BIT_CNT_W'(1);
                            // Flags, raw bytes and preamble bypass stuffing
                            if (st.tx_raw || st.tx_kind == SNBL_KIND_FLAG
                                    || st.tx_kind == SNBL_KIND_PRE) begin
                                next_st.tx_ones = '0;
                            end else if (out_bit) begin
                                next_st.tx_ones = st.tx_ones + 3'd1;
                                next_st.tx_stuff = (st.tx_ones == 3'(STUFF_RUN - 1));
                            end else begin
                                next_st.tx_ones = '0;
                            end
                        end
                        // NRZI: toggle on 0, hold on 1
                        next_st.tx_level = nrzi_on ? (out_bit ? st.tx_level : ~st.tx_level)
                                                   : out_bit;
                    end
                    // Byte done once all 8 bits and any pending stuff bit left
                    if (next_st.tx_bits == BIT_CNT_W'(8) && !next_st.tx_stuff) begin
                        if (st.tx_is_last) begin
                            next_st.tx_st = SNBL_TX_IFS;
                            next_st.ifs_cnt = interframe_space_count;
                        end else begin
                            next_st.tx_st = SNBL_TX_IDLE;
                            next_st.tx_ready = 1'b1;
                        end
                    end
                end
                SNBL_TX_IFS: begin
                    // Last bit keeps its whole bit time; rest and driver off at next tick,
                    // then spacing is counted in bit times
                    if (st.tick) begin
                        next_st.den_n = 1'b1;
                        next_st.tx_level = LINE_REST;
                        if (st.den_n) begin
                            if (st.ifs_cnt == '0) begin
                                next_st.tx_st = SNBL_TX_IDLE;
                            end else begin
                                next_st.ifs_cnt = st.ifs_cnt - 8'd1;
                            end
                        end
                    end
                end
                default: next_st.tx_st = SNBL_TX_IDLE;
            endcase
        end

        // Clear first so an abort in the same cycle still sets the flag
        if (rx_abort_clear) begin
            next_st.abort_flag = 1'b0;
        end

        // Receive side; works on decoded bits from the NRZI decoder
        if (rb_valid && rx_enable_bit) begin
            flag_n = {rb_value, st.flag_sh[7:1]};
            next_st.flag_sh = flag_n;
            if (rb_run == RUN_W'(ABORT_RUN)) begin
                // Abort: flag only when data already went to the queue
                if (st.in_frame && st.got_data) begin
                    next_st.abort_flag = 1'b1;
                end
                next_st.in_frame = 1'b0;
                next_st.got_data = 1'b0;
                next_st.rx_hold_ok = 1'b0;
            end else if (flag_n == FLAG_BYTE) begin
                // Closing flag may open the next frame; the last held byte
                // is CRC and is dropped without reaching the queue
                if (st.in_frame && st.got_data && st.rx_bits == BIT_CNT_W'(7)) begin
                    next_st.rx_end = 1'b1;
                end
                next_st.in_frame = 1'b1;
                next_st.got_data = 1'b0;
                next_st.rx_hold_ok = 1'b0;
                next_st.rx_bits = '0;
            end else if (st.in_frame) begin
                if (!(rb_value == 1'b0 && st.flag_sh[7:3] == 5'b1_1111)) begin
                    next_st.rx_sh = {rb_value, st.rx_sh[7:1]};
                    if (st.rx_bits == BIT_CNT_W'(7)) begin
                        // Delay one byte so flag bits never reach the queue
                        next_st.rx_bits = '0;
                        if (st.rx_hold_ok) begin
                            next_st.rx_out.data = st.rx_hold;
                            next_st.rx_out_valid = 1'b1;
                            next_st.got_data = 1'b1;
                        end
                        next_st.rx_hold = {rb_value, st.rx_sh[7:1]};
                        next_st.rx_hold_ok = 1'b1;
                    end else begin
                        next_st.rx_bits = st.rx_bits + BIT_CNT_W'(1);
                    end
                end
            end
        end
        // Idle run uses the same counter as abort, so no restart
        if (rb_valid && rb_run >= RUN_W'(IDLE_RUN)) begin
            next_st.idle_flag = 1'b1;
        end else if (line_idle_clear) begin
            next_st.idle_flag = 1'b0;
        end
        next_st.rx_out.last = next_st.rx_end;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.tx_level <= LINE_REST;
            st.den_n <= 1'b1;
            st.tx_st <= SNBL_TX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign tx_ready               = st.tx_ready;
    assign tx_line                = st.tx_level;
    assign line_driver_enable_out = st.den_n;
    assign rx_byte                = st.rx_out;
    assign rx_byte_valid          = st.rx_out_valid;
    assign rx_frame_end           = st.rx_end;
    assign rx_abort_flag          = st.abort_flag;
    assign line_idle_flag         = st.idle_flag;
endmodule

// ==== testbench/snbl_monitor.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module snbl_monitor
    import snbl_pkg::*;
#(
    parameter logic [DIV_W-1:0] BIT_DIV = 4
)(
    input wire logic mclk,
    input wire logic reset,
    input wire logic tx_enable_bit,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_line,
    input wire logic line_driver_enable_out,
    input wire logic rx_abort_clear,
    input wire logic line_idle_clear,
    input wire logic rx_byte_valid,
    input wire logic rx_frame_end,
    input wire logic rx_abort_flag,
    input wire logic line_idle_flag
);
    logic [7:0] hold;
    logic       lvl;

    // Cycles the serial output kept its level, saturating
    always_ff @(posedge mclk) begin
        lvl  <= tx_line;
        hold <= (reset || tx_line != lvl) ? 8'h00 : hold + 8'(hold != 8'hFF);
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    rest_a: assert property ($past(reset) |-> tx_line && line_driver_enable_out)
        else $error("line not at rest after reset");
    abort_high_a: assert property (!tx_enable_bit [*2] |-> tx_line)
        else $error("disabled output not high");
    abort_end_a: assert property (!tx_enable_bit [*6] |-> line_driver_enable_out)
        else $error("driver still on while disabled");
    take_walk_a: assert property (tx_valid && tx_ready && tx_enable_bit |=>
        !line_driver_enable_out && !tx_ready)
        else $error("byte take did not start shifting");
    // Abort may cut a bit short and frame end goes to rest with the driver off, so both are left out
    bit_hold_a: assert property (tx_line != lvl && tx_enable_bit && $past(tx_enable_bit)
        && !line_driver_enable_out |-> hold >= BIT_DIV - 1)
        else $error("bit shorter than a bit time");
    ifs_wait_a: assert property ($rose(line_driver_enable_out) |-> !tx_ready [*8])
        else $error("byte accepted inside spacing");
    abort_keep_a: assert property ($past(rx_abort_flag) && !$past(rx_abort_clear)
        |-> rx_abort_flag)
        else $error("abort flag lost");
    idle_keep_a: assert property ($past(line_idle_flag) && !$past(line_idle_clear)
        |-> line_idle_flag)
        else $error("idle flag lost");
    byte_gap_a: assert property (rx_byte_valid |=> !rx_byte_valid [*8])
        else $error("received bytes too close");
    frame_end_a: assert property (rx_frame_end |=> !rx_frame_end [*8])
        else $error("frame ends too close");
endmodule

bind snbl_line snbl_monitor #(.BIT_DIV(BIT_DIV)) u_snbl_monitor (
    .mclk(mclk), .reset(reset), .tx_enable_bit(tx_enable_bit), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_line(tx_line), .line_driver_enable_out(line_driver_enable_out),
    .rx_abort_clear(rx_abort_clear), .line_idle_clear(line_idle_clear),
    .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
    .rx_abort_flag(rx_abort_flag), .line_idle_flag(line_idle_flag)
);

// ==== testbench/snbl_remote.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Remote station: NRZI sender and listener
// ----------------------------------------
module snbl_remote
    import snbl_pkg::*;
#(
    parameter int unsigned BIT_DIV = 4
)(
    input  wire logic mclk,
    input  wire logic tx_line,
    input  wire logic line_driver_enable_out,
    output logic      rx_line
);
    logic lvl;
    logic prev;
    logic locked;
    int   cnt;
    logic got[$];

    initial begin
        rx_line = LINE_REST;
        lvl = 1'b1;
        prev = 1'b1;
        locked = 1'b0;
        cnt = 0;
    end

    // LSB first, one bit time each; the line is never released, idle holds the level
    task automatic send(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            if (!v[i]) rx_line <= ~rx_line;
            repeat (BIT_DIV) @(posedge mclk);
        end
    endtask

    // Relock on every edge, sample mid bit, decode against previous level
    always @(posedge mclk) begin
        lvl <= tx_line;
        cnt <= (tx_line != lvl) ? 1 : cnt + 1;
        if (line_driver_enable_out) begin
            locked <= 1'b0;
            prev <= tx_line;
        end else begin
            if (tx_line != lvl) locked <= 1'b1;
            if (locked && cnt % BIT_DIV == BIT_DIV / 2) begin
                got.push_back(tx_line == prev);
                prev <= tx_line;
            end
        end
    end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Line layer bench
// ----------------------------------------
module tb;
    import snbl_pkg::*;
    localparam int unsigned BD = 4;
    logic          mclk, reset, sdlc_mode, internal_baud, raw_mode, tx_enable_bit;
    logic          rx_enable_bit, tx_valid, tx_last, tx_ready, tx_line, drv_en, rx_line;
    logic          line_idle_clear, rx_abort_clear, rx_byte_valid, rx_frame_end;
    logic          rx_abort_flag, line_idle_flag, stay_hi;
    logic [7:0]    interframe_space_count;
    logic [7:0]    rxq[$];
    logic          exp_q[$];
    snbl_tx_byte_t tx_byte_queue;
    snbl_rx_byte_t rx_byte;
    int            n_fail, checks_done, cyc, n_end, run, wait_n;

    snbl_line #(.BIT_DIV(DIV_W'(BD))) i_snbl_line (
        .mclk(mclk), .reset(reset), .sdlc_mode(sdlc_mode), .internal_baud(internal_baud),
        .raw_mode(raw_mode), .tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit),
        .interframe_space_count(interframe_space_count), .tx_byte_queue(tx_byte_queue),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .tx_line(tx_line),
        .line_driver_enable_out(drv_en), .rx_line(rx_line),
        .line_idle_clear(line_idle_clear), .rx_abort_clear(rx_abort_clear),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
        .rx_abort_flag(rx_abort_flag), .line_idle_flag(line_idle_flag)
    );
    snbl_remote #(.BIT_DIV(BD)) remote (
        .mclk(mclk), .tx_line(tx_line), .line_driver_enable_out(drv_en), .rx_line(rx_line)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard and receive collector
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rx_byte_valid === 1'b1) rxq.push_back(rx_byte.data);
        if (rx_frame_end === 1'b1) begin
            n_end++;
            check(rx_byte.last, 1'b1);
        end
        if (cyc == 40000) begin
            n_fail++;
            give_verdict();
        end
    end

    // Hand one byte over and queue the bits it should put on the line
    task automatic put(input logic [7:0] d, input snbl_kind_t k, input logic raw, last);
        logic b;
        wait_n = 0;
        stay_hi = 1'b1;
        tx_byte_queue <= '{data: d, kind: k};
        raw_mode <= raw;
        tx_last <= last;
        tx_valid <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            b = (k == SNBL_KIND_CRC) ? d[7-i] : d[i];
            if (k == SNBL_KIND_PRE) b = PREAMBLE_B[i];
            exp_q.push_back(b);
            run = (b && !raw && (k == SNBL_KIND_DATA || k == SNBL_KIND_CRC)) ? run + 1 : 0;
            if (run == STUFF_RUN) begin
                exp_q.push_back(1'b0);
                run = 0;
            end
        end
        @(posedge mclk);
        while (tx_ready !== 1'b1 && wait_n < 400) begin
            stay_hi &= (tx_line === 1'b1);
            wait_n++;
            @(posedge mclk);
        end
        if (wait_n == 400) n_fail++;
        tx_valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wait_end();
        for (int w = 0; w < 2000 && drv_en !== 1'b1; w++) @(posedge mclk);
    endtask

    // Zeros break any ones run, then both flags are cleared
    task automatic clr_flags();
        fork
            remote.send(32'h0000_0000, 3);
            begin
                repeat (2 * BD) @(posedge mclk);
                line_idle_clear <= 1'b1;
                rx_abort_clear <= 1'b1;
                @(posedge mclk);
                line_idle_clear <= 1'b0;
                rx_abort_clear <= 1'b0;
            end
        join
    endtask

    // Stuffing across a byte edge, CRC order, raw ones inside the frame
    task automatic t_frame();
        remote.got.delete();
        exp_q.delete();
        run = 0;
        put(FLAG_BYTE, SNBL_KIND_FLAG, 1'b0, 1'b0);
        put(8'h00, SNBL_KIND_PRE, 1'b0, 1'b0);
        put(8'hE0, SNBL_KIND_DATA, 1'b0, 1'b0);
        put(8'h03, SNBL_KIND_DATA, 1'b0, 1'b0);
        put(8'hA5, SNBL_KIND_CRC, 1'b0, 1'b0);
        put(RAW_ONES, SNBL_KIND_DATA, 1'b1, 1'b0);
        put(FLAG_BYTE, SNBL_KIND_FLAG, 1'b0, 1'b1);
        wait_end();
        check(remote.got.size(), exp_q.size());
        foreach (exp_q[i]) check(remote.got[i], exp_q[i]);
        $display("frame transmit done");
    endtask

    // Either mode input low leaves the line uncoded
    task automatic t_modes();
        logic [7:0] v;
        for (int m = 0; m < 2; m++) begin
            sdlc_mode <= m[0];
            internal_baud <= ~m[0];
            remote.got.delete();
            put(FLAG_BYTE, SNBL_KIND_FLAG, 1'b0, 1'b1);
            wait_end();
            for (int i = 0; i < 8; i++) v[i] = remote.got[i];
            check(v, 8'h7C);
        end
        sdlc_mode <= 1'b1;
        internal_baud <= 1'b1;
        $display("mode select done");
    endtask

    // Abort by disable, re-enabled at once; spacing holds the next frame
    task automatic t_abort();
        put(FLAG_BYTE, SNBL_KIND_FLAG, 1'b0, 1'b0);
        put(8'h00, SNBL_KIND_DATA, 1'b0, 1'b0);
        tx_enable_bit <= 1'b0;
        @(posedge mclk);
        tx_enable_bit <= 1'b1;
        put(FLAG_BYTE, SNBL_KIND_FLAG, 1'b0, 1'b1);
        check(stay_hi, 1'b1);
        check(wait_n >= 7 * BD, 1'b1);
        wait_end();
        // Abort held off by software for seven bit times
        put(FLAG_BYTE, SNBL_KIND_FLAG, 1'b0, 1'b0);
        tx_enable_bit <= 1'b0;
        repeat (7 * BD) @(posedge mclk);
        check({tx_line, drv_en}, 2'b11);
        tx_enable_bit <= 1'b1;
        wait_end();
        $display("transmit abort done");
    endtask

    // Zero preamble, stuffed zero removed, last held byte dropped
    task automatic t_rx();
        clr_flags();
        rxq.delete();
        n_end = 0;
        remote.send(32'h0000_0000, 16);
        remote.send(32'(FLAG_BYTE), 8);
        remote.send(32'h0000_03E0, 17);
        remote.send(32'h0000_00AB, 8);
        remote.send(32'(FLAG_BYTE), 8);
        repeat (3 * BD) @(posedge mclk);
        check(rxq.size(), 2);
        check(rxq[0], 8'hE0);
        check(rxq[1], 8'h03);
        check(n_end, 1);
        $display("receive frame done");
    endtask

    // Abort with data held, then idle threshold counted through an abort
    task automatic t_rx_runs();
        clr_flags();
        remote.send(32'(FLAG_BYTE), 8);
        remote.send(32'h0056_3412, 24);
        remote.send(32'h0000_3FFF, 14);
        remote.send(32'h0000_0000, 1);
        repeat (2 * BD) @(posedge mclk);
        check(rx_abort_flag, 1'b1);
        check(line_idle_flag, 1'b0);
        clr_flags();
        remote.send(32'h0000_127E, 16);
        remote.send(32'h0000_7FFF, 15);
        remote.send(32'h0000_0000, 1);
        repeat (2 * BD) @(posedge mclk);
        check(line_idle_flag, 1'b1);
        check(rx_abort_flag, 1'b0);
        $display("receive runs done");
    endtask

    initial begin
        reset = 1'b1;
        sdlc_mode = 1'b1;
        internal_baud = 1'b1;
        raw_mode = 1'b0;
        tx_enable_bit = 1'b1;
        rx_enable_bit = 1'b1;
        interframe_space_count = 8'h08;
        tx_byte_queue = '0;
        tx_valid = 1'b0;
        tx_last = 1'b0;
        line_idle_clear = 1'b0;
        rx_abort_clear = 1'b0;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        run = 0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        check({tx_line, drv_en, rx_abort_flag, line_idle_flag}, 4'hC);
        t_frame();
        t_modes();
        t_abort();
        t_rx();
        t_rx_runs();
        give_verdict();
    end
endmodule
